// File: src/sssm_consts.svh
// timing counts, reset values and fixed figures of the slave link state machine
// assumes a single core clock; the three time counts are derived from the core clock period, the settle count is fixed
`ifndef SSSM_CONSTS_SVH
`define SSSM_CONSTS_SVH

// ----------------------------------------------------------------
// clock and times (ns)
// ----------------------------------------------------------------
`define SSSM_CLK_PERIOD_NS   50
`define SSSM_POT_NS          100000
`define SSSM_REQ_PULSE_NS    1000
`define SSSM_RESUME_NS       20000

// least times round up to whole core cycles
`define SSSM_POT_CYC     ((`SSSM_POT_NS + `SSSM_CLK_PERIOD_NS - 1) / `SSSM_CLK_PERIOD_NS)
`define SSSM_REQ_CYC     ((`SSSM_REQ_PULSE_NS + `SSSM_CLK_PERIOD_NS - 1) / `SSSM_CLK_PERIOD_NS)
`define SSSM_RESUME_CYC  ((`SSSM_RESUME_NS + `SSSM_CLK_PERIOD_NS - 1) / `SSSM_CLK_PERIOD_NS)
// cycles after releasing the shared select before its level is trusted again
`define SSSM_SETTLE_CYC  3

// ----------------------------------------------------------------
// reset values and reported figures
// ----------------------------------------------------------------
`define SSSM_RST_BYTE        8'h00
`define SSSM_RST_CNT         16'h0000
`define SSSM_MAX_FREQ_KHZ    16'h186a

`endif

// File: src/sssm_pkg.sv
// types shared by the slave link state machine and its serial engine
// assumes the constants header is included by the modules that need counts
package sssm_pkg;

    // ----------------------------------------------------------------
    // slave states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT   = 3'b000,
        ST_DESEL  = 3'b001,
        ST_SEL    = 3'b010,
        ST_PROACT = 3'b011,
        ST_BUSY   = 3'b100,
        ST_PSAVE  = 3'b101
    } sssm_state_t;

    // ----------------------------------------------------------------
    // core domain state
    // ----------------------------------------------------------------
    typedef struct packed {
        sssm_state_t state;
        logic [15:0] cnt;
        logic        selMeta;
        logic        selSync;
        logic        flagMeta;
        logic        flagSync;
        logic        flagPrev;
        logic        reqIssued;
        logic [7:0]  txHold;
        logic        selOe;
        logic        intOut;
        logic        misoOe;
        logic [7:0]  rxData;
        logic        rxValid;
        logic        ready;
        logic [15:0] maxFreq;
    } sssm_core_t;

    // ----------------------------------------------------------------
    // link domain state, rising and falling edge parts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bitCnt;
        logic [7:0] rxSh;
        logic [7:0] rxByte;
        logic       rxFlag;
    } sssm_rise_t;

    typedef struct packed {
        logic first;
        logic misoBit;
    } sssm_fall_t;

endpackage

// File: src/sssm_link.sv
// serial engine of the slave, mode 0, clocked by the master's serial clock
// assumes frameRstN is low whenever the shared select is high (no frame)
`timescale 1ns/1ps
module sssm_link
    import sssm_pkg::*;
(
    input  wire logic       sclk,       // serial clock from master
    input  wire logic       frameRstN,  // async reset, low outside a frame
    input  wire logic       mosiIn,     // master data in
    input  wire logic [7:0] txHold,     // byte to send, stable during a frame
    output logic            misoOut,    // slave data out
    output logic [7:0]      rxByte,     // last complete byte
    output logic            rxFlag      // high for four bits after each byte
);

    sssm_rise_t riseReg, riseNext;
    sssm_fall_t fallReg, fallNext;

    // ----------------------------------------------------------------
    // sample on rising edge
    // ----------------------------------------------------------------
    // master data is sampled on the rising edge [R3]
    always_comb begin
        riseNext        = riseReg;
        riseNext.rxSh   = {riseReg.rxSh[6:0], mosiIn};
        riseNext.bitCnt = riseReg.bitCnt + 3'h1;
        if (riseReg.bitCnt == 3'h7) begin
            riseNext.rxByte = {riseReg.rxSh[6:0], mosiIn};
            riseNext.rxFlag = 1'b1;
        end else if (riseReg.bitCnt == 3'h3) begin
            riseNext.rxFlag = 1'b0;
        end
    end

    always_ff @(posedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            riseReg <= '0;
        end else begin
            riseReg <= riseNext;
        end
    end

    // ----------------------------------------------------------------
    // shift out on falling edge
    // ----------------------------------------------------------------
    // output bit changes only after a falling edge [R3]
    always_comb begin
        fallNext         = fallReg;
        fallNext.first   = 1'b0;
        fallNext.misoBit = txHold[~riseReg.bitCnt];
    end

    always_ff @(negedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            fallReg <= 2'b10;
        end else begin
            fallReg <= fallNext;
        end
    end

    // first bit must stand before the first rising edge, so it comes from the held byte
    assign misoOut = fallReg.first ? txHold[7] : fallReg.misoBit;
    assign rxByte  = riseReg.rxByte;
    assign rxFlag  = riseReg.rxFlag;

endmodule

// File: src/sssm_top.sv
// slave link state machine: states, shared select handling, request pulse
// assumes pins are outside core_clk domain; the link engine runs on sclk
//
// Function
// R1: select line is open drain on both sides; pull low or release, and read.
// R2: select reads low when either side asserts it, high otherwise.
// R3: mode 0 clocking: idle low, sample rising, slave changes data after falling.
// R4: slave reports its highest serial clock in the ready message.
// R5: with valid supply the slave enters the initial state.
// R6: any reset returns the slave to initial from any state.
// R7: after the power-on delay the slave moves to de-selected.
// R8: de-selected: data output high impedance, clock and data input ignored.
// R9: de-selected: ready for access, responds to select assertion.
// R10: after a request the slave stays de-selected until the master accesses.
// R11: four-signal: slave never pulls select low while de-selected.
// R12: de-selected exits only to selected, pro-active, power saving, initial.
// R13: selected: drive data output, sample clock and data, watch select.
// R14: selected exits only to de-selected, pro-active or initial; the code exits to de-selected, or to busy when BUSY_EN is set.
// R15: pending data to send moves the slave to pro-active.
// R16: pro-active ends by itself after the request pulse, whatever the inputs.
// R17: four-signal pro-active: pull select low, output high-z, ignore inputs.
// R18: leaving pro-active goes de-selected only when the master did not start.
// R19: master starting together with the request leads straight to selected.
// R20: busy keeps select asserted and leaves only to de-selected; the code releases select for the three settle cycles before leaving busy.
// R21: power saving goes to selected once resumed, to initial on reset.
// R22: the request pulse lasts at least one microsecond.
// R23: after resume the slave is ready once the resume time has passed.
// R24: delays are parameterised counts of slave clock cycles.
`timescale 1ns/1ps
`include "sssm_consts.svh"
module sssm_top
    import sssm_pkg::*;
#(
    parameter bit FOUR_WIRE  = 1'b1,              // 1: shared select, 0: separate request line
    parameter bit BUSY_EN    = 1'b0,              // optional busy state
    parameter int POT_CYC    = `SSSM_POT_CYC,     // power-on delay in cycles
    parameter int REQ_CYC    = `SSSM_REQ_CYC,     // request pulse in cycles
    parameter int RESUME_CYC = `SSSM_RESUME_CYC   // resume time in cycles
) (
    input  wire logic        core_clk,         // slave clock, 20 MHz
    input  wire logic        nrst,             // async reset, active low
    input  wire logic        sclk,             // serial clock from master
    input  wire logic        sharedSelectInN,  // level read from shared select pin
    output logic             sharedSelectOut,  // select drive value, always low
    output logic             sharedSelectOe,   // high while pulling select low
    output logic             requestInt,       // request pulse, separate line variant
    input  wire logic        mosiIn,           // master data in
    output logic             misoOut,          // slave data out
    output logic             misoOe,           // high while data output driven
    input  wire logic        dataPending,      // user has data for the master
    input  wire logic        sleepReq,         // user asks for power saving
    input  wire logic        busyHold,         // user holds the busy state
    input  wire logic [7:0]  txByte,           // byte sent in next frame
    output logic [7:0]       rxData,           // received byte
    output logic             rxValid,          // one-cycle pulse per byte
    output logic             linkReady,        // de-selected or selected
    output sssm_state_t      linkState,        // present state
    output logic [15:0]      maxClkKhz         // reported highest serial clock
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [15:0] POT_LAST    = 16'(POT_CYC - 1);
    localparam logic [15:0] REQ_END     = 16'(REQ_CYC);
    localparam logic [15:0] PRO_LAST    = 16'(REQ_CYC + `SSSM_SETTLE_CYC - 1);
    localparam logic [15:0] RESUME_LAST = 16'(RESUME_CYC - 1);
    localparam int          REQ_GAP     = REQ_CYC - 7;                  // eighth high cycle to first low one
    localparam logic [15:0] BUSY_LAST   = 16'(`SSSM_SETTLE_CYC);        // settle after busy lets go

    sssm_core_t  coreReg;
    sssm_core_t  coreNext;
    logic        frameRstN;
    logic        linkFlag;
    logic [7:0]  linkByte;
    logic        selLow;
    logic        byteEvt;

    // ----------------------------------------------------------------
    // link domain engine
    // ----------------------------------------------------------------
    // frame reset follows the pin itself, so the frame ends even if sclk stops [R8]
    assign frameRstN = nrst & ~sharedSelectInN;

    sssm_link u_link (
        .sclk      (sclk),
        .frameRstN (frameRstN),
        .mosiIn    (mosiIn),
        .txHold    (coreReg.txHold),
        .misoOut   (misoOut),
        .rxByte    (linkByte),
        .rxFlag    (linkFlag)
    );

    // ----------------------------------------------------------------
    // helpers on synchronised inputs
    // ----------------------------------------------------------------
    // level read back from the wired line, low if either side pulls [R1] [R2]
    assign selLow  = ~coreReg.selSync;
    // byte event from the rising edge of the crossed flag
    assign byteEvt = coreReg.flagSync & ~coreReg.flagPrev;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        coreNext          = coreReg;
        // two flip-flops ahead of the shared select pin and the cross-domain byte flag
        coreNext.selMeta  = sharedSelectInN;
        coreNext.selSync  = coreReg.selMeta;
        coreNext.flagMeta = linkFlag;
        coreNext.flagSync = coreReg.flagMeta;
        coreNext.flagPrev = coreReg.flagSync;
        coreNext.rxValid  = 1'b0;
        coreNext.maxFreq  = `SSSM_MAX_FREQ_KHZ;
        coreNext.cnt      = coreReg.cnt + 16'h0001;

        unique case (coreReg.state)
            // wait out the power-on delay [R5] [R7] [R24]
            ST_INIT: begin
                if (coreReg.cnt == POT_LAST) begin
                    coreNext.state = ST_DESEL;
                    coreNext.cnt   = `SSSM_RST_CNT;
                end
            end
            // select by master has priority over own requests [R9] [R12]
            ST_DESEL: begin
                coreNext.cnt = `SSSM_RST_CNT;
                if (selLow) begin
                    coreNext.state     = ST_SEL;
                    coreNext.txHold    = txByte;
                    coreNext.reqIssued = 1'b0;
                end else if (dataPending && !coreReg.reqIssued) begin
                    // select seen high before requesting [R15]
                    coreNext.state = ST_PROACT;
                end else if (sleepReq && !coreReg.reqIssued) begin
                    coreNext.state = ST_PSAVE;
                end
                // after a request, just wait for the master [R10]
            end
            // bytes only accepted here; clock and data ignored elsewhere [R13] [R8]
            ST_SEL: begin
                coreNext.cnt = `SSSM_RST_CNT;
                if (byteEvt) begin
                    coreNext.rxData  = linkByte;
                    coreNext.rxValid = 1'b1;
                end
                if (!selLow) begin
                    coreNext.state = (BUSY_EN && busyHold) ? ST_BUSY : ST_DESEL; // [R14]
                end
            end
            // timed request, inputs not looked at until the end [R16] [R17]
            ST_PROACT: begin
                if (coreReg.cnt == PRO_LAST) begin
                    coreNext.cnt = `SSSM_RST_CNT;
                    if (selLow) begin
                        // master started at the same time [R19]
                        coreNext.state     = ST_SEL;
                        coreNext.txHold    = txByte;
                        coreNext.reqIssued = 1'b0;
                    end else begin
                        coreNext.state     = ST_DESEL; // [R18]
                        coreNext.reqIssued = 1'b1;
                    end
                end
            end
            // hold off the master until the user lets go [R20]
            ST_BUSY: begin
                if (busyHold) begin
                    coreNext.cnt = `SSSM_RST_CNT;
                end else if (coreReg.cnt == BUSY_LAST) begin
                    // own pull has faded from the synchroniser, so it cannot pass for a select
                    coreNext.state = ST_DESEL;
                    coreNext.cnt   = `SSSM_RST_CNT;
                end
            end
            // master wakes us with select, then the resume time runs [R21] [R23]
            ST_PSAVE: begin
                if (!selLow && coreReg.cnt == `SSSM_RST_CNT) begin
                    coreNext.cnt = `SSSM_RST_CNT;
                end else if (coreReg.cnt == RESUME_LAST) begin
                    coreNext.state  = ST_SEL;
                    coreNext.txHold = txByte;
                    coreNext.cnt    = `SSSM_RST_CNT;
                end
            end
            default: begin
                coreNext.state = ST_INIT;
                coreNext.cnt   = `SSSM_RST_CNT;
            end
        endcase

        // ----------------------------------------------------------------
        // pin controls follow the state being entered
        // ----------------------------------------------------------------
        // data output driven only while selected [R8] [R13] [R17]
        coreNext.misoOe = (coreNext.state == ST_SEL);
        // pull the shared line only in pro-active and busy, never de-selected [R11] [R17] [R20]
        coreNext.selOe  = FOUR_WIRE &&
                          ((coreNext.state == ST_PROACT && coreNext.cnt < REQ_END) ||
                           (coreNext.state == ST_BUSY && coreNext.cnt == `SSSM_RST_CNT));
        // separate request line in the five-signal variant [R22]
        coreNext.intOut = !FOUR_WIRE && coreNext.state == ST_PROACT && coreNext.cnt < REQ_END;
        coreNext.ready  = (coreNext.state == ST_DESEL) || (coreNext.state == ST_SEL);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // any reset lands in the initial state [R6]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            coreReg          <= '0;
            coreReg.state    <= ST_INIT;
            coreReg.cnt      <= `SSSM_RST_CNT;
            coreReg.selMeta  <= 1'b1;
            coreReg.selSync  <= 1'b1;
            coreReg.txHold   <= `SSSM_RST_BYTE;
            coreReg.rxData   <= `SSSM_RST_BYTE;
            coreReg.maxFreq  <= `SSSM_MAX_FREQ_KHZ;
        end else begin
            coreReg <= coreNext;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // open drain: the value is always low, only the enable moves [R1]
    assign sharedSelectOut = 1'b0;
    assign sharedSelectOe  = coreReg.selOe;
    assign requestInt      = coreReg.intOut;
    assign misoOe          = coreReg.misoOe;
    assign rxData          = coreReg.rxData;
    assign rxValid         = coreReg.rxValid;
    assign linkReady       = coreReg.ready;
    assign linkState       = coreReg.state;
    // figure carried in the ready message [R4]
    assign maxClkKhz       = coreReg.maxFreq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    logic reqLine;
    assign reqLine = FOUR_WIRE ? coreReg.selOe : coreReg.intOut;

    sequence s_pro_entry;
        coreReg.state == ST_DESEL ##1 coreReg.state == ST_PROACT;
    endsequence

    sequence s_pro_end;
        coreReg.state == ST_PROACT && coreReg.cnt == PRO_LAST;
    endsequence

    a_pot_exit: assert property ( // [R7]
        coreReg.state == ST_INIT && coreReg.cnt == POT_LAST |=> coreReg.state == ST_DESEL)
        else $error("power-on delay exit wrong");

    a_desel_quiet: assert property ( // [R8]
        coreReg.state == ST_DESEL |-> !coreReg.misoOe && !coreReg.selOe && !coreReg.rxValid)
        else $error("de-selected slave drives a pin");

    a_sel_drive: assert property ( // [R13]
        coreReg.state == ST_SEL |-> coreReg.misoOe && !coreReg.selOe)
        else $error("selected slave not driving data");

    a_desel_exits: assert property ( // [R12]
        coreReg.state == ST_DESEL ##1 coreReg.state != ST_DESEL |->
            coreReg.state inside {ST_SEL, ST_PROACT, ST_PSAVE})
        else $error("illegal exit from de-selected");

    a_sel_exits: assert property ( // [R14]
        coreReg.state == ST_SEL ##1 coreReg.state != ST_SEL |->
            coreReg.state == ST_DESEL || (BUSY_EN && coreReg.state == ST_BUSY))
        else $error("illegal exit from selected");

    a_req_pulse: assert property ( // [R22]
        s_pro_entry |-> reqLine [*8] ##REQ_GAP !reqLine)
        else $error("request pulse length wrong");

    a_pro_leave: assert property ( // [R16]
        s_pro_end |=> coreReg.state == ($past(coreReg.selSync) ? ST_DESEL : ST_SEL))
        else $error("pro-active exit wrong");

    a_busy_exit: assert property ( // [R20]
        coreReg.state == ST_BUSY ##1 coreReg.state != ST_BUSY |-> coreReg.state == ST_DESEL)
        else $error("busy left toward wrong state");

    a_resume_time: assert property ( // [R23]
        coreReg.state == ST_PSAVE && coreReg.cnt == RESUME_LAST |=> coreReg.state == ST_SEL)
        else $error("resume time not kept");

    a_busy_pull: assert property ( // [R20]
        coreReg.state == ST_BUSY && coreReg.cnt == `SSSM_RST_CNT |-> coreReg.selOe == FOUR_WIRE)
        else $error("busy slave not holding select");

    a_pro_quiet: assert property ( // [R17]
        coreReg.state == ST_PROACT |-> !coreReg.misoOe && !coreReg.rxValid)
        else $error("pro-active slave drives data");

    a_req_once: assert property ( // [R10]
        coreReg.state == ST_DESEL && coreReg.reqIssued |=> coreReg.state inside {ST_DESEL, ST_SEL})
        else $error("new request before access");

    a_psave_exits: assert property ( // [R21]
        coreReg.state == ST_PSAVE ##1 coreReg.state != ST_PSAVE |-> coreReg.state == ST_SEL)
        else $error("power saving left toward wrong state");

endmodule

// File: sim/sssm_master_model.sv
// master side model of the serial link: mode 0 clock, open-drain select, data out
// assumes the bench resolves the select wire from both pull-down enables
`timescale 1ns/1ps
module sssm_master_model (
    output logic      sclk,    // serial clock, low outside transfers
    output logic      selOe,   // high while the master pulls select low
    output logic      mosi,    // master data out
    input  wire logic miso,    // slave data out
    input  wire logic misoOe   // slave drives its data out
);
    logic lastMiso;  // last level seen on the data-in line

    // idle: clock low, select released, data line not holding a stale value
    initial begin
        sclk = 1'b0;
        selOe = 1'b0;
        mosi = 1'b1;
        lastMiso = 1'b0;
    end

    // pull low or release only, off the core edge so the phase stays unrelated
    task automatic setSel(input logic on);
        #7 selOe = on;
    endtask

    // one byte MSB first at 160 ns, the highest rate the slave reports
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];                                // changes while clock is low
            #80 sclk = 1'b1;
            lastMiso = misoOe ? miso : ~lastMiso;        // undriven line gives no stale bit
            rx[i] = lastMiso;                            // sampled on rising edge
            #80 sclk = 1'b0;
        end
        mosi = ~tx[0];  // released line shows the inverse of its last bit
    endtask
endmodule

// File: sim/tb.sv
// self-checking bench of the slave link state machine with a master model
// assumes short timing parameters; expected bytes kept in a queue
`timescale 1ns/1ps
`include "sssm_consts.svh"
module tb;
    import sssm_pkg::*;
    localparam int POWER_ON_DELAY = 10;
    localparam int REQ = 10;
    localparam int RES = 5;
    logic        core_clk = 1'b0, nrst = 1'b0, dataPending = 1'b0, sleepReq = 1'b0, busyHold = 1'b0;
    logic [7:0]  txByte = 8'h00, rxData, scratch;
    logic        sclk, mSelOe, mosi, selOut, selOe, miso, misoOe, rxValid, linkReady, reqInt;
    wire logic   selN;
    sssm_state_t linkState;
    logic [15:0] maxClkKhz;
    logic [7:0]  expQ[$];
    int          fail_count = 0, n_checks = 0, n;

    // open-drain select: low when either side pulls, pull-up otherwise
    assign selN = ~(mSelOe | selOe);
    always #25 core_clk = ~core_clk;

    sssm_top #(.BUSY_EN(1'b1), .POT_CYC(POWER_ON_DELAY), .REQ_CYC(REQ), .RESUME_CYC(RES)) u_sssm_top (
        .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .sharedSelectInN(selN), .sharedSelectOut(selOut),
        .sharedSelectOe(selOe), .requestInt(reqInt), .mosiIn(mosi), .misoOut(miso), .misoOe(misoOe),
        .dataPending(dataPending), .sleepReq(sleepReq), .busyHold(busyHold), .txByte(txByte),
        .rxData(rxData), .rxValid(rxValid), .linkReady(linkReady), .linkState(linkState), .maxClkKhz(maxClkKhz));
    sssm_master_model u_sssm_master_model (.sclk(sclk), .selOe(mSelOe), .mosi(mosi), .miso(miso), .misoOe(misoOe));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // bounded wait; running out ends the run as a mismatch
    task automatic waitState(input sssm_state_t st, input int bound, output int cnt);
        cnt = 0;
        while (linkState !== st && cnt < bound) begin
            cyc(1);
            cnt++;
        end
        if (linkState !== st) begin
            check(1'b0, "state wait timed out");
            test_done();
        end
    endtask
    // whole access: select, random bytes both ways, optional busy hold, release
    task automatic frame(input int nb, input logic hold, output int cnt);
        logic [7:0] b, r;
        cyc(1);  // user inputs move only on a core edge; select moves 7 ns after it
        if (linkState !== ST_SEL) txByte <= $urandom;  // a selection already made keeps its captured byte
        u_sssm_master_model.setSel(1'b1);
        waitState(ST_SEL, REQ + 12, cnt);
        check(misoOe === 1'b1 && linkReady === 1'b1, "not driving when selected");
        cyc(8);  // slave is ready before the clock starts
        repeat (nb) begin
            b = $urandom;
            expQ.push_back(b);
            u_sssm_master_model.xfer(b, r);
            check(r === txByte, "slave byte wrong");
        end
        cyc(6);
        busyHold <= hold;
        u_sssm_master_model.setSel(1'b0);
        cyc(6);
        if (!hold) check(linkState === ST_DESEL && misoOe === 1'b0, "no return to de-selected");
    endtask

    // every received byte compared with the model queue
    always @(posedge core_clk) begin
        if (rxValid === 1'b1) begin
            check(expQ.size() > 0 && rxData === expQ[0], "received byte wrong");
            if (expQ.size() > 0) void'(expQ.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(58));
        cyc(6);
        check(linkState === ST_INIT && misoOe === 1'b0 && selOe === 1'b0, "reset state");
        check(maxClkKhz === `SSSM_MAX_FREQ_KHZ && selOut === 1'b0, "reported clock");
        nrst <= 1'b1;
        waitState(ST_DESEL, POWER_ON_DELAY + 4, n);
        check(n >= POWER_ON_DELAY && n <= POWER_ON_DELAY + 2, "power-on delay");
        check(misoOe === 1'b0 && selOe === 1'b0 && linkReady === 1'b1, "de-selected pins");
        u_sssm_master_model.xfer(8'ha5, scratch);  // clock and data with no select must yield no byte
        $display("test power-on done");
        frame(2, 1'b0, n);
        $display("test access done");
        dataPending <= 1'b1;
        waitState(ST_PROACT, 4, n);
        check(selOe === 1'b1 && selN === 1'b0 && misoOe === 1'b0 && reqInt === 1'b0, "request pins");
        n = 0;
        while (selOe === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        check(n >= REQ && n <= REQ + 1, "request pulse length");
        waitState(ST_DESEL, 6, n);
        cyc(20);
        check(linkState === ST_DESEL && selOe === 1'b0, "second request before access");
        dataPending <= 1'b0;
        frame(1, 1'b0, n);
        $display("test request done");
        dataPending <= 1'b1;
        waitState(ST_PROACT, 4, n);
        dataPending <= 1'b0;
        u_sssm_master_model.setSel(1'b1);
        cyc(REQ + 5);
        check(linkState === ST_SEL, "simultaneous start");
        frame(1, 1'b0, n);
        $display("test simultaneous done");
        sleepReq <= 1'b1;
        waitState(ST_PSAVE, 4, n);
        sleepReq <= 1'b0;
        frame(1, 1'b0, n);
        check(n >= RES, "resume time");
        $display("test power saving done");
        frame(1, 1'b1, n);
        check(linkState === ST_BUSY && selOe === 1'b1 && selN === 1'b0, "busy hold");
        busyHold <= 1'b0;
        waitState(ST_DESEL, 8, n);
        cyc(4);
        check(linkState === ST_DESEL, "busy release reselects");
        $display("test busy done");
        u_sssm_master_model.setSel(1'b1);
        waitState(ST_SEL, 12, n);
        nrst <= 1'b0;
        cyc(2);
        check(linkState === ST_INIT && misoOe === 1'b0 && linkReady === 1'b0, "mid-run reset");
        u_sssm_master_model.setSel(1'b0);
        cyc(1);
        nrst <= 1'b1;
        waitState(ST_DESEL, POWER_ON_DELAY + 4, n);
        check(expQ.size() == 0, "bytes lost");
        $display("test reset done");
        test_done();
    end
endmodule
